// File: design/lrr_pkg.sv
/*
  Shared constants and types of the reset-source and retention block:
  register map, field positions, reset values, option byte codes and timing.
  Assumes a 40 MHz system clock and 32-bit AXI4-Lite data.
*/
package lrr_pkg;

  // Clock and RTC timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned RTC_TICK_MS     = 1000;
  localparam int unsigned RTC_TICK_CYCLES = CLK_HZ / 1000 * RTC_TICK_MS;

  // Detector thresholds, for reference by the analog comparators
  localparam int unsigned LVD_RISE_MV = 2810;
  localparam int unsigned LVD_FALL_MV = 2750;

  // Register byte addresses
  localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;
  localparam logic [7:0] ADDR_RESET_SRC = 8'h00;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h04;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h08;
  localparam logic [7:0] ADDR_OPT_VIEW  = 8'h0C;
  localparam logic [7:0] ADDR_RTC_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_RTC_SEC   = 8'h14;
  localparam logic [7:0] ADDR_RTC_MIN   = 8'h18;
  localparam logic [7:0] ADDR_RTC_HOUR  = 8'h1C;

  // Field positions
  localparam int unsigned RSF_LVD_BIT  = 0;
  localparam int unsigned INT_LVD_BIT  = 0;
  localparam int unsigned INT_SEC_BIT  = 1;
  localparam int unsigned INT_W        = 2;
  localparam int unsigned RTC_RUN_BIT  = 0;

  // Reset values
  localparam logic             LVD_FLAG_RST = 1'b0;
  localparam logic [INT_W-1:0] INT_STAT_RST = 2'h0;
  localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;
  localparam logic             RTC_RUN_RST  = 1'b0;
  localparam logic [7:0]       OPT_RST      = 8'h00;

  // Option byte codes
  localparam logic [7:0] OPT_WDT_STOP       = 8'h6E;
  localparam logic [7:0] OPT_LVD_RESET_MODE = 8'h7F;
  localparam logic [7:0] OPT_OSC_HS_24MHZ   = 8'hE0;
  localparam logic [7:0] OPT_OCD_ENABLE     = 8'h84;

  // Calendar limits and selectors
  localparam logic [7:0] RTC_SEC_MAX  = 8'h3B;
  localparam logic [7:0] RTC_MIN_MAX  = 8'h3B;
  localparam logic [7:0] RTC_HOUR_MAX = 8'h17;

  typedef enum logic [1:0] {
    LRR_CAL_SEC  = 2'h0,
    LRR_CAL_MIN  = 2'h1,
    LRR_CAL_HOUR = 2'h2
  } lrr_cal_sel_t;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    LRR_ST_NORMAL    = 1'h0,
    LRR_ST_LVD_RESET = 1'h1
  } lrr_lvd_state_t;

endpackage : lrr_pkg

// File: design/lrr_rtc_if.sv
/*
  Link between the control top and the RTC counter core.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface lrr_rtc_if;
  import lrr_pkg::*;
  logic         tick;
  logic         run_en;
  logic         cal_wr_en;
  lrr_cal_sel_t cal_sel;
  logic [7:0]   wr_data;
  logic [7:0]   sec;
  logic [7:0]   min;
  logic [7:0]   hour;

  modport ctrl (output tick, output run_en, output cal_wr_en, output cal_sel,
                output wr_data, input sec, input min, input hour);
  modport core (input tick, input run_en, input cal_wr_en, input cal_sel,
                input wr_data, output sec, output min, output hour);
endinterface : lrr_rtc_if

// File: design/lrr_rtc_core.sv
/*
  RTC calendar counters: seconds, minutes, hours.
  Assumes tick is a one-cycle pulse per second and that writes come from
  the control top. No reset reaches these counters by design.
*/
`timescale 1ns/100ps
module lrr_rtc_core (
  input wire logic clk,
  lrr_rtc_if.core  rtc
);
  import lrr_pkg::*;

  logic [7:0] sec_q,  sec_d;
  logic [7:0] min_q,  min_d;
  logic [7:0] hour_q, hour_d;

  always_comb begin
    sec_d  = sec_q;
    min_d  = min_q;
    hour_d = hour_q;
    if (rtc.cal_wr_en) begin
      unique case (rtc.cal_sel)
        LRR_CAL_SEC:  sec_d  = rtc.wr_data;
        LRR_CAL_MIN:  min_d  = rtc.wr_data;
        LRR_CAL_HOUR: hour_d = rtc.wr_data;
        default:      sec_d  = sec_q;
      endcase
    end else if (rtc.tick && rtc.run_en) begin
      if (sec_q >= RTC_SEC_MAX) begin
        sec_d = 8'h00;
        if (min_q >= RTC_MIN_MAX) begin
          min_d  = 8'h00;
          hour_d = (hour_q >= RTC_HOUR_MAX) ? 8'h00 : hour_q + 8'h01;
        end else begin
          min_d = min_q + 8'h01;
        end
      end else begin
        sec_d = sec_q + 8'h01;
      end
    end
  end

  // Counters keep their value through every reset, power-on included
  always_ff @(posedge clk) begin
    sec_q  <= sec_d;
    min_q  <= min_d;
    hour_q <= hour_d;
  end

  assign rtc.sec  = sec_q;
  assign rtc.min  = min_q;
  assign rtc.hour = hour_q;

endmodule : lrr_rtc_core

// File: design/lrr_top.sv
/*
  Reset-source and retention top: low-voltage detector reset, read-to-clear
  detector flag, option byte decode, RTC control and AXI4-Lite slave.
  Assumes rst_b is the power-on reset, the two supply comparator pins are
  asynchronous, and the option bytes are stable from reset onward.
*/
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module lrr_top #(
  parameter int unsigned TICK_CYCLES = lrr_pkg::RTC_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        vdd_below_fall,
  input  wire logic        vdd_at_rise,
  input  wire logic [7:0]  opt_wdt,
  input  wire logic [7:0]  opt_lvd,
  input  wire logic [7:0]  opt_osc,
  input  wire logic [7:0]  opt_ocd,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_rst_b,
  output logic             wdt_count_en,
  output logic             osc_hs_24mhz,
  output logic             ocd_enable,
  output logic             irq
);
  import lrr_pkg::*;

  localparam int unsigned CNT_W = $clog2(TICK_CYCLES);

  lrr_rtc_if rtc_bus ();

  // Supply comparator synchronisers
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic       below_s;
  logic       at_rise_s;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {vdd_at_rise, vdd_below_fall};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign below_s   = pin_sync_q[0];
  assign at_rise_s = pin_sync_q[1];

  // Option bytes, caught once after power-on reset release
  logic       opt_valid_q, opt_valid_d;
  logic [7:0] opt_wdt_q, opt_wdt_d;
  logic [7:0] opt_lvd_q, opt_lvd_d;
  logic [7:0] opt_osc_q, opt_osc_d;
  logic [7:0] opt_ocd_q, opt_ocd_d;

  always_comb begin
    opt_valid_d = 1'b1;
    opt_wdt_d   = opt_valid_q ? opt_wdt_q : opt_wdt;
    opt_lvd_d   = opt_valid_q ? opt_lvd_q : opt_lvd;
    opt_osc_d   = opt_valid_q ? opt_osc_q : opt_osc;
    opt_ocd_d   = opt_valid_q ? opt_ocd_q : opt_ocd;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      opt_valid_q <= 1'b0;
      opt_wdt_q   <= OPT_RST;
      opt_lvd_q   <= OPT_RST;
      opt_osc_q   <= OPT_RST;
      opt_ocd_q   <= OPT_RST;
    end else begin
      opt_valid_q <= opt_valid_d;
      opt_wdt_q   <= opt_wdt_d;
      opt_lvd_q   <= opt_lvd_d;
      opt_osc_q   <= opt_osc_d;
      opt_ocd_q   <= opt_ocd_d;
    end
  end

  logic lvd_mode;

  assign lvd_mode     = opt_valid_q && (opt_lvd_q == OPT_LVD_RESET_MODE);
  // Watchdog stays stopped until the options are known
  assign wdt_count_en = opt_valid_q && (opt_wdt_q != OPT_WDT_STOP);
  assign osc_hs_24mhz = opt_valid_q && (opt_osc_q == OPT_OSC_HS_24MHZ);
  assign ocd_enable   = opt_valid_q && (opt_ocd_q == OPT_OCD_ENABLE);

  // Detector reset state
  lrr_lvd_state_t lvd_state_q, lvd_state_d;
  logic           lvd_enter;

  always_comb begin
    lvd_state_d = lvd_state_q;
    lvd_enter   = 1'b0;
    unique case (lvd_state_q)
      LRR_ST_NORMAL: begin
        if (lvd_mode && below_s) begin
          lvd_state_d = LRR_ST_LVD_RESET;
          lvd_enter   = 1'b1;
        end
      end
      LRR_ST_LVD_RESET: begin
        // Hysteresis: only the rising comparator ends the reset
        if (at_rise_s) begin
          lvd_state_d = LRR_ST_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvd_state_q <= LRR_ST_NORMAL;
    end else begin
      lvd_state_q <= lvd_state_d;
    end
  end

  assign cpu_rst_b = rst_b && (lvd_state_q == LRR_ST_NORMAL);

  // One-second enable for the RTC
  logic [CNT_W-1:0] tick_cnt_q, tick_cnt_d;
  logic             tick;

  assign tick = (tick_cnt_q == CNT_W'(TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_d = tick ? '0 : tick_cnt_q + CNT_W'(1);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Register file and AXI4-Lite slave
  logic             aw_full_q, aw_full_d;
  logic [7:0]       awaddr_q, awaddr_d;
  logic             w_full_q, w_full_d;
  logic [31:0]      wdata_q, wdata_d;
  logic             wstrb0_q, wstrb0_d;
  logic             bvalid_q, bvalid_d;
  logic [1:0]       bresp_q, bresp_d;
  logic             rvalid_q, rvalid_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [1:0]       rresp_q, rresp_d;
  logic             lvd_flag_q, lvd_flag_d;
  logic [INT_W-1:0] int_stat_q, int_stat_d;
  logic [INT_W-1:0] int_mask_q, int_mask_d;
  logic             rtc_run_q, rtc_run_d;
  logic             do_write;
  logic             flag_rd_clr;
  logic [INT_W-1:0] stat_w1c;
  logic [INT_W-1:0] stat_set;
  logic             cal_wr_en;
  lrr_cal_sel_t     cal_sel;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_arready = !rvalid_q;

  always_comb begin
    aw_full_d   = aw_full_q;
    awaddr_d    = awaddr_q;
    w_full_d    = w_full_q;
    wdata_d     = wdata_q;
    wstrb0_d    = wstrb0_q;
    bvalid_d    = bvalid_q;
    bresp_d     = bresp_q;
    rvalid_d    = rvalid_q;
    rdata_d     = rdata_q;
    rresp_d     = rresp_q;
    int_mask_d  = int_mask_q;
    rtc_run_d   = rtc_run_q;
    do_write    = aw_full_q && w_full_q && !bvalid_q;
    flag_rd_clr = 1'b0;
    stat_w1c    = '0;
    cal_wr_en   = 1'b0;
    cal_sel     = LRR_CAL_SEC;

    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end

    // All writable fields sit in byte lane 0, so only that strobe matters
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      unique case (awaddr_q & ADDR_WORD_MASK)
        ADDR_RESET_SRC, ADDR_OPT_VIEW: ;
        ADDR_INT_STAT: stat_w1c = wstrb0_q ? wdata_q[INT_W-1:0] : '0;
        ADDR_INT_MASK: int_mask_d = wstrb0_q ? wdata_q[INT_W-1:0] : int_mask_q;
        ADDR_RTC_CTRL: rtc_run_d = wstrb0_q ? wdata_q[RTC_RUN_BIT] : rtc_run_q;
        ADDR_RTC_SEC: begin
          cal_wr_en = wstrb0_q;
          cal_sel   = LRR_CAL_SEC;
        end
        ADDR_RTC_MIN: begin
          cal_wr_en = wstrb0_q;
          cal_sel   = LRR_CAL_MIN;
        end
        ADDR_RTC_HOUR: begin
          cal_wr_en = wstrb0_q;
          cal_sel   = LRR_CAL_HOUR;
        end
        default: bresp_d = RESP_SLVERR;
      endcase
    end

    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      unique case (s_axi_araddr & ADDR_WORD_MASK)
        ADDR_RESET_SRC: begin
          rdata_d[RSF_LVD_BIT] = lvd_flag_q;
          flag_rd_clr          = 1'b1;
        end
        ADDR_INT_STAT: rdata_d[INT_W-1:0] = int_stat_q;
        ADDR_INT_MASK: rdata_d[INT_W-1:0] = int_mask_q;
        ADDR_OPT_VIEW: rdata_d = {opt_ocd_q, opt_osc_q, opt_lvd_q, opt_wdt_q};
        ADDR_RTC_CTRL: rdata_d[RTC_RUN_BIT] = rtc_run_q;
        ADDR_RTC_SEC:  rdata_d[7:0] = rtc_bus.sec;
        ADDR_RTC_MIN:  rdata_d[7:0] = rtc_bus.min;
        ADDR_RTC_HOUR: rdata_d[7:0] = rtc_bus.hour;
        default:       rresp_d = RESP_SLVERR;
      endcase
    end

    // A detector reset in the cycle of the clearing read still wins
    lvd_flag_d = (lvd_state_q == LRR_ST_LVD_RESET) || (lvd_flag_q && !flag_rd_clr);
    stat_set   = '0;
    stat_set[INT_LVD_BIT] = lvd_enter;
    stat_set[INT_SEC_BIT] = tick && rtc_run_q;
    int_stat_d = stat_set | (int_stat_q & ~stat_w1c);
  end

  // Only the power-on reset reaches these; the detector reset leaves them
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_full_q  <= 1'b0;
      awaddr_q   <= 8'h00;
      w_full_q   <= 1'b0;
      wdata_q    <= 32'h0000_0000;
      wstrb0_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
      lvd_flag_q <= LVD_FLAG_RST;
      int_stat_q <= INT_STAT_RST;
      int_mask_q <= INT_MASK_RST;
      rtc_run_q  <= RTC_RUN_RST;
    end else begin
      aw_full_q  <= aw_full_d;
      awaddr_q   <= awaddr_d;
      w_full_q   <= w_full_d;
      wdata_q    <= wdata_d;
      wstrb0_q   <= wstrb0_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      lvd_flag_q <= lvd_flag_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      rtc_run_q  <= rtc_run_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
  assign irq          = |(int_stat_q & int_mask_q);

  assign rtc_bus.tick      = tick;
  assign rtc_bus.run_en    = rtc_run_q;
  assign rtc_bus.cal_wr_en = cal_wr_en;
  assign rtc_bus.cal_sel   = cal_sel;
  assign rtc_bus.wr_data   = wdata_q[7:0];

  lrr_rtc_core u_rtc (
    .clk (clk),
    .rtc (rtc_bus.core)
  );

  // Checks
  a_por_clears: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> (!lvd_flag_q && !rtc_run_q))
    else $error("power-on reset left flag or RTC control set");

  a_lvd_assert: assert property (@(posedge clk) disable iff (!rst_b)
    (lvd_mode && below_s && lvd_state_q == LRR_ST_NORMAL) |=> !cpu_rst_b)
    else $error("detector reset not raised below threshold");

  a_lvd_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (lvd_state_q == LRR_ST_LVD_RESET && !at_rise_s) |=> !cpu_rst_b)
    else $error("detector reset dropped before supply recovered");

  a_lvd_release: assert property (@(posedge clk) disable iff (!rst_b)
    (lvd_state_q == LRR_ST_LVD_RESET && at_rise_s) |=> cpu_rst_b)
    else $error("detector reset not released at threshold");

  a_rtc_counts_thru: assert property (@(posedge clk) disable iff (!rst_b)
    (lvd_state_q == LRR_ST_LVD_RESET && tick && rtc_run_q && !cal_wr_en
     && rtc_bus.sec < RTC_SEC_MAX) |=> (rtc_bus.sec == $past(rtc_bus.sec) + 8'h01))
    else $error("RTC stopped counting during detector reset");

  a_flag_set_lvd: assert property (@(posedge clk) disable iff (!rst_b)
    (lvd_state_q == LRR_ST_LVD_RESET) |=> lvd_flag_q)
    else $error("flag not set by detector reset");

  a_flag_read_val: assert property (@(posedge clk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && (s_axi_araddr & ADDR_WORD_MASK) == ADDR_RESET_SRC)
    |=> (s_axi_rvalid && s_axi_rdata[RSF_LVD_BIT] == $past(lvd_flag_q)))
    else $error("reset source read returned wrong flag");

  a_flag_read_clr: assert property (@(posedge clk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && (s_axi_araddr & ADDR_WORD_MASK) == ADDR_RESET_SRC
     && lvd_state_q == LRR_ST_NORMAL) |=> !lvd_flag_q)
    else $error("flag not cleared by read");

  a_wdt_stopped: assert property (@(posedge clk) disable iff (!rst_b)
    (opt_valid_q && opt_wdt_q == OPT_WDT_STOP) |-> !wdt_count_en [*2])
    else $error("watchdog runs with stop option");

  a_osc_hs_mode: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(opt_valid_q) && $past(opt_osc) == OPT_OSC_HS_24MHZ |-> osc_hs_24mhz)
    else $error("oscillator option not decoded");

  c_lvd_cycle: cover property (@(posedge clk) disable iff (!rst_b)
    !cpu_rst_b ##[1:1000] cpu_rst_b);
  c_flag_read: cover property (@(posedge clk) disable iff (!rst_b)
    s_axi_rvalid && s_axi_rdata[RSF_LVD_BIT]);
  c_cal_write: cover property (@(posedge clk) disable iff (!rst_b)
    cal_wr_en);

endmodule : lrr_top

// File: dv/lrr_supply_model.sv
/*
  Behavioural supply monitor facing the reset-source block: two comparators
  with hysteresis between the falling and rising detection levels.
  Assumes the bench sets the supply level in millivolts off the clock edge.
*/
`timescale 1ns/100ps
module lrr_supply_model
  import lrr_pkg::*;
(
  input  wire logic [31:0] vdd_mv,
  output logic             below_fall,
  output logic             at_rise
);
  // Levels are compared without delay; the block synchronises both pins itself
  assign below_fall = (vdd_mv < LVD_FALL_MV);
  assign at_rise    = (vdd_mv >= LVD_RISE_MV);
endmodule : lrr_supply_model

// File: dv/lrr_top_tb_top.sv
/*
  Self-checking bench of the reset-source block: register table walk, detector
  reset and release, read-to-clear flag, power-on reset retention, options.
  Assumes the hand-over latencies: detector reset and release show 3 edges on.
*/
`timescale 1ns/100ps
module lrr_top_tb_top;
  import lrr_pkg::*;
  localparam int unsigned TICK = 8;
  logic clk = 1'b0, rst_b = 1'b0;
  int unsigned vdd_mv = 3300;
  logic vdd_below_fall, vdd_at_rise;
  logic [7:0] opt_wdt = OPT_WDT_STOP, opt_lvd = OPT_LVD_RESET_MODE;
  logic [7:0] opt_osc = OPT_OSC_HS_24MHZ, opt_ocd = OPT_OCD_ENABLE;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cpu_rst_b, wdt_count_en, osc_hs_24mhz;
  logic ocd_enable, irq;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] last_data, s1, saved;
  int num_errors = 0, n_checks = 0;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} lrr_row_t;
  lrr_row_t rows [6];

  always #12.5 clk = ~clk;

  lrr_supply_model u_lrr_supply_model (.vdd_mv(vdd_mv), .below_fall(vdd_below_fall),
                                       .at_rise(vdd_at_rise));
  lrr_top #(.TICK_CYCLES(TICK)) u_lrr_top (
    .clk(clk), .rst_b(rst_b), .vdd_below_fall(vdd_below_fall), .vdd_at_rise(vdd_at_rise),
    .opt_wdt(opt_wdt), .opt_lvd(opt_lvd), .opt_osc(opt_osc), .opt_ocd(opt_ocd),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_rst_b(cpu_rst_b), .wdt_count_en(wdt_count_en),
    .osc_hs_24mhz(osc_hs_24mhz), .ocd_enable(ocd_enable), .irq(irq));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, so the taking edge is known race-free
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, done;
    int n;
    done = 1'b0;
    n = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!done && n < 100) begin
      @(negedge clk);
      n++;
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      done = bvalid;
      last_resp = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
    chk("write answered", 1'b1, done);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    logic ar_t, done;
    int n;
    done = 1'b0;
    n = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done && n < 100) begin
      @(negedge clk);
      n++;
      ar_t = arvalid && arready;
      done = rvalid;
      last_data = rdata;
      last_resp = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
    chk("read answered", 1'b1, done);
  endtask : axi_rd

  task automatic set_vdd(input int unsigned mv);
    @(posedge clk);
    vdd_mv <= mv;
  endtask : set_vdd

  // Detector reset and release both land on the third edge after the pin moves
  task automatic expect_cpu_rst(input logic lvl);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("cpu_rst_b early", !lvl, cpu_rst_b);
    @(negedge clk);
    chk("cpu_rst_b", lvl, cpu_rst_b);
  endtask : expect_cpu_rst

  task automatic power_on_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : power_on_reset

  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    $display("unexpected timeout expected finish seen hang");
    tally_and_finish();
  end

  initial begin
    rows = '{'{ADDR_RESET_SRC, 32'h0, RESP_OKAY}, '{ADDR_INT_STAT, 32'h0, RESP_OKAY},
             '{ADDR_INT_MASK, 32'h0, RESP_OKAY}, '{ADDR_OPT_VIEW, 32'h84E07F6E, RESP_OKAY},
             '{ADDR_RTC_CTRL, 32'h0, RESP_OKAY}, '{8'h40, 32'h0, RESP_SLVERR}};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("cpu_rst_b", 1'b1, cpu_rst_b);
    chk("wdt_count_en", 1'b0, wdt_count_en);
    chk("osc_hs_24mhz", 1'b1, osc_hs_24mhz);
    chk("ocd_enable", 1'b1, ocd_enable);
    foreach (rows[i]) begin
      axi_rd(rows[i].a);
      chk("row rdata", rows[i].d, last_data);
      chk("row rresp", rows[i].r, last_resp);
    end
    axi_wr(ADDR_OPT_VIEW, 32'h0);
    axi_rd(ADDR_OPT_VIEW);
    chk("option view read-only", 32'h84E07F6E, last_data);
    axi_wr(8'h40, 32'h1);
    chk("unmapped bresp", RESP_SLVERR, last_resp);
    axi_wr(ADDR_RTC_SEC, 32'h0);
    axi_wr(ADDR_RTC_MIN, 32'h7);
    axi_wr(ADDR_RTC_HOUR, 32'h5);
    axi_wr(ADDR_RTC_CTRL, 32'h1);
    axi_wr(ADDR_INT_MASK, 32'h1);
    chk("irq idle", 1'b0, irq);
    // Detector reset while the calendar runs
    axi_rd(ADDR_RTC_SEC);
    s1 = last_data;
    set_vdd(2700);
    expect_cpu_rst(1'b0);
    @(negedge clk);
    chk("irq on detector reset", 1'b1, irq);
    repeat (4 * TICK) @(posedge clk);
    axi_rd(ADDR_RTC_SEC);
    n_checks++;
    if ((last_data + 60 - s1) % 60 < 4 || (last_data + 60 - s1) % 60 > 6) begin
      num_errors++;
      $display("unexpected rtc seconds advance expected 4 to 6 seen %0d",
               (last_data + 60 - s1) % 60);
    end
    axi_rd(ADDR_RESET_SRC);
    chk("flag held in reset", 32'h1, last_data);
    // Between the two levels the reset must hold
    set_vdd(2780);
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("cpu_rst_b hysteresis", 1'b0, cpu_rst_b);
    set_vdd(2810);
    expect_cpu_rst(1'b1);
    // Startup firmware saves the flag once, then decides on RTC setup
    axi_rd(ADDR_RESET_SRC);
    saved = last_data;
    chk("flag first read", 32'h1, saved);
    axi_rd(ADDR_RESET_SRC);
    chk("flag after read", 32'h0, last_data);
    if (saved[RSF_LVD_BIT] !== 1'b1) begin
      axi_wr(ADDR_RTC_CTRL, 32'h0);
    end
    axi_rd(ADDR_RTC_CTRL);
    chk("rtc run retained", 32'h1, last_data);
    axi_wr(ADDR_INT_STAT, 32'h1);
    @(negedge clk);
    chk("irq after clear", 1'b0, irq);
    axi_rd(ADDR_INT_STAT);
    chk("status bit cleared", 1'b0, last_data[INT_LVD_BIT]);
    // Detector reset left unread, then power-on reset with other options
    set_vdd(2700);
    expect_cpu_rst(1'b0);
    set_vdd(3300);
    expect_cpu_rst(1'b1);
    @(posedge clk);
    opt_wdt <= 8'h00;
    opt_lvd <= 8'h00;
    opt_osc <= 8'h00;
    opt_ocd <= 8'h00;
    power_on_reset();
    @(negedge clk);
    chk("wdt_count_en", 1'b1, wdt_count_en);
    chk("osc_hs_24mhz", 1'b0, osc_hs_24mhz);
    chk("ocd_enable", 1'b0, ocd_enable);
    axi_rd(ADDR_RESET_SRC);
    chk("flag after power-on", 32'h0, last_data);
    axi_rd(ADDR_RTC_CTRL);
    chk("rtc control after power-on", 32'h0, last_data);
    axi_rd(ADDR_RTC_HOUR);
    chk("rtc hour after power-on", 32'h5, last_data);
    set_vdd(2700);
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("cpu_rst_b without reset mode", 1'b1, cpu_rst_b);
    tally_and_finish();
  end
endmodule : lrr_top_tb_top
